// *** hw/crw_top.sv ***
// clock selection, dividers, flash wait states, watchdog, reset and power control
//
// Overview of operation
// - sixteen 16-bit dividers of the root clock
// - twelve peripheral dividers, four programmable-logic dividers
// - source switch free of glitches and metastability
// - root selector offers six oscillator sources
// - analog clock leads the digital clock of divider 0 by one cycle
// - main oscillator 24 MHz, 3..48 step 1
// - pll makes 48 MHz from the crystal
// - two flash wait states at 48 MHz
// - one flash wait state at 24 MHz
// - watchdog counts low-speed oscillator ticks
// - watchdog keeps counting in deep sleep
// - missed watchdog service resets the chip
// - watchdog reset flagged in reset cause
// - reset cause survives the reset it reports
// - every reset forces defined state
// - software reset and dedicated external reset pin
// - brown-out resets, low voltage interrupts
// - power-on waits for supply good
// - six power modes managed here
`timescale 1ns/1ps
`default_nettype none

module crw_top import crw_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire crw_apb_req_t apb_req_i,
    output crw_apb_rsp_t apb_rsp_o,
    input wire logic lso_clk_i,
    input wire logic external_reset_pin_n_i,
    input wire logic brownout_detector_i,
    input wire logic low_voltage_detector_i,
    input wire logic supply_good_i,
    input wire logic wake_i,
    output logic [2:0] root_sel_o,
    output logic root_gate_o,
    output logic pll_enable_o,
    output logic [5:0] imo_freq_o,
    output logic [1:0] flash_wait_states_o,
    output logic [NUM_PER_DIV-1:0] per_clk_en_o,
    output logic [NUM_PLB_DIV-1:0] plb_clk_en_o,
    output logic analog_clk_en_o,
    output logic chip_reset_o,
    output logic low_voltage_irq_o,
    output logic [5:0] power_mode_o
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        crw_apb_rsp_t rsp; // registered bus answer
        crw_src_t root_req; // source software asked for
        crw_src_t root_sel; // source in use
        logic gate; // root clock let through
        logic [2:0] gap; // cycles left with clocks off
        logic pll_en;
        logic [5:0] internal_main_oscillator; // main oscillator setting in MHz
        logic [1:0] ws; // flash wait states
        logic [NUM_DIV-1:0][15:0] dpend; // written divide values
        logic [NUM_DIV-1:0][15:0] dcnt; // running down-counters
        logic [NUM_DIV-1:0] dout; // one-cycle enables
        logic ana; // analog enable, one cycle ahead
        logic wen;
        logic [15:0] wmatch;
        logic [15:0] wcnt;
        logic [3:0] cause; // sticky reset causes
        logic [3:0] rcnt; // chip reset cycles left
        logic chip_rst;
        logic [1:0] lso_s; // synchronisers: [0] feeds [1] only
        logic lso_p;
        logic [1:0] external_reset_pin_s;
        logic [1:0] bod_s;
        logic [1:0] lvd_s;
        logic [1:0] pg_s;
        logic [1:0] wake_s;
        logic lvd_q;
        crw_pmode_t pm;
    } crw_st_t;

    crw_st_t s_q; // registered state
    crw_st_t s_d; // next state
    crw_st_t keep; // next state saved across a chip reset
    logic acc; // access phase
    logic wr; // write committed this edge
    logic hit; // address mapped
    logic [31:0] rd; // read mux
    logic [4:0] dsel; // divider decode {hit, index}
    logic lso_edge; // one tick of the slow oscillator
    logic wdt_to; // watchdog expiry
    logic svc; // watchdog serviced
    logic sw_rst; // software reset request
    logic [3:0] cset; // cause bits set now
    logic [3:0] cclr; // cause bits cleared by software
    logic [2:0] preq; // power mode request
    logic preq_v;

    // ************************************************************
    // helpers
    // ************************************************************
    // reset image; cause starts clear only at power-on
    function automatic crw_st_t init_st();
        crw_st_t s;
        s = '0;
        s.internal_main_oscillator = IMO_RST_MHZ;
        s.gate = 1'b1;
        s.wmatch = WDT_MATCH_RST;
        s.pm = PM_POR;
        return s;
    endfunction : init_st

    // divider register decode, shared by reads and writes
    function automatic logic [4:0] div_dec(input logic [11:0] a);
        logic [11:0] off;
        off = a - OFF_DIV_BASE;
        div_dec = {(a >= OFF_DIV_BASE) && (off < 12'h040) && (off[1:0] == 2'h0),
                   off[5:2]};
    endfunction : div_dec

    // clock rate of a source, for wait-state choice
    function automatic logic [5:0] src_mhz(input crw_src_t s, input logic [5:0] internal_main_oscillator);
        src_mhz = (s == SRC_IMO) ? internal_main_oscillator : ((s == SRC_PLL) ? PLL_MHZ : UNKNOWN_MHZ);
    endfunction : src_mhz

    // wait states per clock rate
    function automatic logic [1:0] ws_for(input logic [5:0] mhz);
        if (mhz > WS2_ABOVE_MHZ) begin
            ws_for = WS_AT_48;
        end else if (mhz > WS1_ABOVE_MHZ) begin
            ws_for = WS_AT_24;
        end else begin
            ws_for = WS_SLOW;
        end
    endfunction : ws_for

    // ************************************************************
    // bus decode
    // ************************************************************
    // one wait state: pready rises in the access phase, the write lands next edge
    always_comb begin
        acc = apb_req_i.psel & apb_req_i.penable;
        wr = acc & s_q.rsp.pready & apb_req_i.pwrite & ~s_q.chip_rst;
        dsel = div_dec(apb_req_i.paddr);
        rd = '0;
        hit = 1'b1;
        case (apb_req_i.paddr)
            OFF_ROOT_SEL: rd[2:0] = s_q.root_req;
            OFF_IMO_FREQ: rd[5:0] = s_q.internal_main_oscillator;
            OFF_STATUS: begin
                rd[ST_PM_LSB +: 6] = s_q.pm;
                rd[ST_WS_LSB +: 2] = s_q.ws;
                rd[ST_BUSY_BIT] = ~s_q.gate | (s_q.root_sel != s_q.root_req);
                rd[ST_PG_BIT] = s_q.pg_s[1];
            end
            OFF_WDT_CTRL: rd[0] = s_q.wen;
            OFF_WDT_MATCH: rd[15:0] = s_q.wmatch;
            OFF_WDT_SVC: rd = '0; // write only
            OFF_WDT_COUNT: rd[15:0] = s_q.wcnt;
            OFF_RST_CAUSE: rd[3:0] = s_q.cause;
            OFF_SW_RST: rd = '0; // write only
            OFF_PWR_REQ: rd = '0; // write only
            default: begin
                // divider window, else unmapped
                if (dsel[4]) begin
                    rd[15:0] = s_q.dpend[dsel[3:0]];
                end else begin
                    hit = 1'b0;
                end
            end
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        keep = s_q;
        svc = 1'b0;
        sw_rst = 1'b0;
        cclr = '0;
        preq = '0;
        preq_v = 1'b0;
        // bus answer, one cycle wide
        s_d.rsp.pready = acc & ~s_q.rsp.pready;
        s_d.rsp.pslverr = acc & ~s_q.rsp.pready & ~hit;
        if (acc & ~s_q.rsp.pready) begin
            s_d.rsp.prdata = rd;
        end
        // pin synchronisers
        s_d.lso_s = {s_q.lso_s[0], lso_clk_i};
        s_d.external_reset_pin_s = {s_q.external_reset_pin_s[0], external_reset_pin_n_i};
        s_d.bod_s = {s_q.bod_s[0], brownout_detector_i};
        s_d.lvd_s = {s_q.lvd_s[0], low_voltage_detector_i};
        s_d.pg_s = {s_q.pg_s[0], supply_good_i};
        s_d.wake_s = {s_q.wake_s[0], wake_i};
        s_d.lso_p = s_q.lso_s[1];
        lso_edge = s_q.lso_s[1] & ~s_q.lso_p;
        s_d.lvd_q = s_q.lvd_s[1]; // interrupt only, no reset

        // register writes
        if (wr) begin
            case (apb_req_i.paddr)
                OFF_ROOT_SEL: begin
                    if (apb_req_i.pwdata[2:0] <= SRC_EXT) begin
                        s_d.root_req = crw_src_t'(apb_req_i.pwdata[2:0]);
                    end
                end
                OFF_IMO_FREQ: begin
                    // out-of-range settings are dropped
                    if ((apb_req_i.pwdata >= 32'(IMO_MIN_MHZ)) &&
                        (apb_req_i.pwdata <= 32'(IMO_MAX_MHZ))) begin
                        s_d.internal_main_oscillator = apb_req_i.pwdata[5:0];
                    end
                end
                OFF_WDT_CTRL: s_d.wen = apb_req_i.pwdata[0];
                OFF_WDT_MATCH: s_d.wmatch = apb_req_i.pwdata[15:0];
                OFF_WDT_SVC: svc = (apb_req_i.pwdata == WDT_SVC_KEY);
                OFF_RST_CAUSE: cclr = apb_req_i.pwdata[3:0];
                OFF_SW_RST: sw_rst = (apb_req_i.pwdata == SW_RST_KEY);
                OFF_PWR_REQ: begin
                    preq = apb_req_i.pwdata[2:0];
                    preq_v = 1'b1;
                end
                default: begin
                    // new divide value waits for the period end
                    if (dsel[4]) begin
                        s_d.dpend[dsel[3:0]] = apb_req_i.pwdata[15:0];
                    end
                end
            endcase
        end

        // dividers: period is value+1 root cycles
        for (int i = 0; i < NUM_DIV; i++) begin
            s_d.dout[i] = 1'b0;
            if (s_q.dcnt[i] == 16'h0000) begin
                s_d.dcnt[i] = s_q.dpend[i];
                s_d.dout[i] = 1'b1;
            end else begin
                s_d.dcnt[i] = s_q.dcnt[i] - 16'h0001;
            end
        end
        // analog enable one cycle before its digital twin
        s_d.ana = (s_q.dcnt[ANA_DIV] == 16'h0001) ||
                  ((s_q.dcnt[ANA_DIV] == 16'h0000) && (s_q.dpend[ANA_DIV] == 16'h0000));

        // root switch: gate off, wait, move select, wait, gate on
        if (s_q.gap != 3'h0) begin
            s_d.gap = s_q.gap - 3'h1;
        end else if (!s_q.gate && (s_q.root_sel != s_q.root_req)) begin
            s_d.root_sel = s_q.root_req;
            s_d.gap = SWITCH_GAP_CYC;
        end else if (!s_q.gate) begin
            s_d.gate = 1'b1;
        end else if (s_q.root_sel != s_q.root_req) begin
            s_d.gate = 1'b0;
            s_d.gap = SWITCH_GAP_CYC;
        end
        s_d.pll_en = (s_q.root_req == SRC_PLL) || (s_q.root_sel == SRC_PLL);
        // wait states cover both old and new source during a switch
        if (ws_for(src_mhz(s_q.root_req, s_q.internal_main_oscillator)) > ws_for(src_mhz(s_q.root_sel, s_q.internal_main_oscillator))) begin
            s_d.ws = ws_for(src_mhz(s_q.root_req, s_q.internal_main_oscillator));
        end else begin
            s_d.ws = ws_for(src_mhz(s_q.root_sel, s_q.internal_main_oscillator));
        end

        // watchdog runs off slow ticks in every power mode
        wdt_to = s_q.wen & lso_edge & (s_q.wcnt >= s_q.wmatch);
        if (svc) begin
            s_d.wcnt = '0;
        end else if (s_q.wen & lso_edge) begin
            s_d.wcnt = wdt_to ? 16'h0000 : s_q.wcnt + 16'h0001;
        end

        // power mode sequencing
        unique case (s_q.pm)
            PM_POR: begin
                if (s_q.pg_s[1]) begin
                    s_d.pm = PM_ACTIVE;
                end
            end
            PM_ACTIVE: begin
                if (preq_v) begin
                    case (preq)
                        PREQ_SLEEP: s_d.pm = PM_SLEEP;
                        PREQ_DEEP: s_d.pm = PM_DEEP;
                        PREQ_HIBER: s_d.pm = PM_HIBER;
                        PREQ_STOP: s_d.pm = PM_STOP;
                        default: s_d.pm = PM_ACTIVE;
                    endcase
                end
            end
            PM_SLEEP, PM_DEEP, PM_HIBER, PM_STOP: begin
                if (s_q.wake_s[1]) begin
                    s_d.pm = PM_ACTIVE;
                end
            end
            default: s_d.pm = PM_POR;
        endcase

        // reset sources; a set beats a clear in the same cycle
        cset = '0;
        cset[CAUSE_EXTERNAL_RESET_PIN] = ~s_q.external_reset_pin_s[1];
        cset[CAUSE_SW] = sw_rst;
        cset[CAUSE_WDT] = wdt_to;
        cset[CAUSE_BOD] = s_q.bod_s[1];
        s_d.cause = (s_q.cause & ~cclr) | cset;
        if (|cset) begin
            s_d.rcnt = RST_HOLD_CYC;
        end else if (s_q.rcnt != 4'h0) begin
            s_d.rcnt = s_q.rcnt - 4'h1;
        end
        s_d.chip_rst = (s_d.rcnt != 4'h0);

        // chip reset wipes all but bus answer, causes, reset counter and flag, synchronisers, slow-tick edge register and low-voltage interrupt flag
        if (s_q.chip_rst) begin
            keep = s_d;
            s_d = init_st();
            s_d.rsp = keep.rsp;
            s_d.cause = keep.cause;
            s_d.rcnt = keep.rcnt;
            s_d.chip_rst = keep.chip_rst;
            s_d.lso_s = keep.lso_s;
            s_d.lso_p = keep.lso_p;
            s_d.external_reset_pin_s = keep.external_reset_pin_s;
            s_d.bod_s = keep.bod_s;
            s_d.lvd_s = keep.lvd_s;
            s_d.pg_s = keep.pg_s;
            s_d.wake_s = keep.wake_s;
            s_d.lvd_q = keep.lvd_q;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // power-on reset loads the reset image for everything, causes included
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_q <= init_st();
        end else begin
            s_q <= s_d;
        end
    end

    // outputs, all straight from state
    assign apb_rsp_o = s_q.rsp;
    assign root_sel_o = s_q.root_sel;
    assign root_gate_o = s_q.gate;
    assign pll_enable_o = s_q.pll_en;
    assign imo_freq_o = s_q.internal_main_oscillator;
    assign flash_wait_states_o = s_q.ws;
    assign per_clk_en_o = s_q.dout[NUM_PER_DIV-1:0];
    assign plb_clk_en_o = s_q.dout[NUM_DIV-1:NUM_PER_DIV];
    assign analog_clk_en_o = s_q.ana;
    assign chip_reset_o = s_q.chip_rst;
    assign low_voltage_irq_o = s_q.lvd_q;
    assign power_mode_o = s_q.pm;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    // a chip reset snaps the select home with the gate open, so it is left out
    chk_switch_gated: assert property ($changed(root_sel_o) && !$past(chip_reset_o)
        |-> !root_gate_o && !$past(root_gate_o))
        else $error("root select moved while clock gated on");
    chk_ana_lead: assert property ($rose(analog_clk_en_o) && !chip_reset_o |=> per_clk_en_o[ANA_DIV])
        else $error("analog enable not followed by digital enable");
    chk_imo_range: assert property (imo_freq_o >= IMO_MIN_MHZ && imo_freq_o <= IMO_MAX_MHZ)
        else $error("main oscillator setting out of range");
    chk_ws_pll: assert property (s_q.root_sel == SRC_PLL && s_q.root_req == SRC_PLL
        && !chip_reset_o |=> flash_wait_states_o == WS_AT_48)
        else $error("wrong wait states at 48 MHz");
    chk_ws_imo24: assert property (s_q.root_sel == SRC_IMO && s_q.root_req == SRC_IMO
        && s_q.internal_main_oscillator == IMO_RST_MHZ && !chip_reset_o |=> flash_wait_states_o == WS_AT_24)
        else $error("wrong wait states at 24 MHz");
    chk_wdt_reset: assert property (wdt_to |=> chip_reset_o && s_q.cause[CAUSE_WDT])
        else $error("watchdog expiry did not reset");
    chk_bod_reset: assert property (s_q.bod_s[1] |=> chip_reset_o && s_q.cause[CAUSE_BOD])
        else $error("brown-out did not reset");
    chk_external_reset_pin_reset: assert property (!s_q.external_reset_pin_s[1] |=> chip_reset_o)
        else $error("external reset pin ignored");
    chk_reset_hold: assert property ($rose(chip_reset_o) |-> chip_reset_o [*8])
        else $error("chip reset too short");
    chk_cause_kept: assert property (chip_reset_o
        |=> (s_q.cause & $past(s_q.cause)) == $past(s_q.cause))
        else $error("reset cause lost in chip reset");
    chk_por_wait: assert property (power_mode_o == PM_POR && !s_q.pg_s[1] |=> power_mode_o == PM_POR)
        else $error("left power-on wait without supply good");
    chk_div_reload: assert property (s_q.dcnt[0] != 16'h0000 && !chip_reset_o
        |=> s_q.dcnt[0] == $past(s_q.dcnt[0]) - 16'h0001)
        else $error("divider reloaded before period end");

    cov_wdt_reset: cover property (wdt_to ##1 chip_reset_o);
    cov_switch: cover property (!root_gate_o ##1 root_gate_o && root_sel_o == SRC_PLL);
    cov_deep: cover property (power_mode_o == PM_DEEP && s_q.wen && lso_edge);
    cov_plb_pulse: cover property (plb_clk_en_o[0] ##1 !plb_clk_en_o[0]);

endmodule : crw_top

`default_nettype wire

// *** pkg/crw_pkg.sv ***
// constants, enums and bus carriers of the clock, reset and watchdog block
package crw_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NUM_DIV = 16; // all dividers
    localparam int NUM_PER_DIV = 12; // fixed-function peripheral dividers
    localparam int NUM_PLB_DIV = 4; // programmable logic dividers
    localparam int ANA_DIV = 0; // divider that also feeds the analog clock

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [11:0] OFF_ROOT_SEL = 12'h000;
    localparam logic [11:0] OFF_IMO_FREQ = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_WDT_CTRL = 12'h00C;
    localparam logic [11:0] OFF_WDT_MATCH = 12'h010;
    localparam logic [11:0] OFF_WDT_SVC = 12'h014;
    localparam logic [11:0] OFF_WDT_COUNT = 12'h018;
    localparam logic [11:0] OFF_RST_CAUSE = 12'h01C;
    localparam logic [11:0] OFF_SW_RST = 12'h020;
    localparam logic [11:0] OFF_PWR_REQ = 12'h024;
    localparam logic [11:0] OFF_DIV_BASE = 12'h040; // divider i at base + 4*i

    // ************************************************************
    // field positions and keys
    // ************************************************************
    localparam int ST_PM_LSB = 0; // status: power mode, 6 bits
    localparam int ST_WS_LSB = 6; // status: flash wait states, 2 bits
    localparam int ST_BUSY_BIT = 8; // status: clock switch in progress
    localparam int ST_PG_BIT = 9; // status: supply good
    localparam int CAUSE_EXTERNAL_RESET_PIN = 0;
    localparam int CAUSE_SW = 1;
    localparam int CAUSE_WDT = 2;
    localparam int CAUSE_BOD = 3;
    localparam logic [31:0] WDT_SVC_KEY = 32'h0000_5A5A;
    localparam logic [31:0] SW_RST_KEY = 32'h0000_A5A5;

    // ************************************************************
    // reset values and frequencies
    // ************************************************************
    localparam logic [5:0] IMO_RST_MHZ = 6'h18; // 24 MHz
    localparam logic [5:0] IMO_MIN_MHZ = 6'h03;
    localparam logic [5:0] IMO_MAX_MHZ = 6'h30; // 48 MHz
    localparam logic [5:0] PLL_MHZ = 6'h30; // pll output from the crystal
    localparam logic [5:0] UNKNOWN_MHZ = 6'h30; // other sources: worst case
    localparam logic [5:0] WS2_ABOVE_MHZ = 6'h18;
    localparam logic [5:0] WS1_ABOVE_MHZ = 6'h0C;
    localparam logic [1:0] WS_AT_48 = 2'h2;
    localparam logic [1:0] WS_AT_24 = 2'h1;
    localparam logic [1:0] WS_SLOW = 2'h0;
    localparam logic [15:0] WDT_MATCH_RST = 16'hFFFF;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int SWITCH_GAP_NS = 30; // both clocks held off this long
    localparam int RST_HOLD_NS = 80; // chip reset pulse width
    localparam logic [2:0] SWITCH_GAP_CYC =
        3'((SWITCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] RST_HOLD_CYC =
        4'((RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ************************************************************
    // enums and carriers
    // ************************************************************
    typedef enum logic [2:0] {
        SRC_IMO = 3'h0, SRC_HFXO = 3'h1, SRC_WCO = 3'h2,
        SRC_PLL = 3'h3, SRC_LSO = 3'h4, SRC_EXT = 3'h5
    } crw_src_t;

    typedef enum logic [5:0] {
        PM_POR = 6'h01, PM_ACTIVE = 6'h02, PM_SLEEP = 6'h04,
        PM_DEEP = 6'h08, PM_HIBER = 6'h10, PM_STOP = 6'h20
    } crw_pmode_t;

    localparam logic [2:0] PREQ_SLEEP = 3'h1;
    localparam logic [2:0] PREQ_DEEP = 3'h2;
    localparam logic [2:0] PREQ_HIBER = 3'h3;
    localparam logic [2:0] PREQ_STOP = 3'h4;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } crw_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } crw_apb_rsp_t;

endpackage : crw_pkg

// *** testbench/tb_top.sv ***
// self-checking bench for the clock, reset and watchdog block
`timescale 1ns/1ps
`default_nettype none
module tb_top import crw_pkg::*;;
    // ************************************************************
    // stimulus and observed signals
    // ************************************************************
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    crw_apb_req_t req = '0; // bus request, idle at start
    crw_apb_rsp_t rsp;
    logic lso = 1'b0, ext_n = 1'b1, brownout_detector = 1'b0, low_voltage_detector = 1'b0, pg = 1'b0, wake = 1'b0;
    logic [2:0] rsel;
    logic gate, pll_en, ana, crst, irq, err, saw_rst, ana_q;
    logic [5:0] internal_main_oscillator, pmode;
    logic [1:0] ws;
    logic [11:0] per;
    logic [3:0] plb;
    logic [31:0] rd;
    int n_errors = 0, cmp_count = 0, np, na, nb;
    crw_top u_crw_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .apb_req_i(req), .apb_rsp_o(rsp),
        .lso_clk_i(lso), .external_reset_pin_n_i(ext_n), .brownout_detector_i(brownout_detector),
        .low_voltage_detector_i(low_voltage_detector), .supply_good_i(pg), .wake_i(wake), .root_sel_o(rsel),
        .root_gate_o(gate), .pll_enable_o(pll_en), .imo_freq_o(internal_main_oscillator), .flash_wait_states_o(ws),
        .per_clk_en_o(per), .plb_clk_en_o(plb), .analog_clk_en_o(ana), .chip_reset_o(crst),
        .low_voltage_irq_o(irq), .power_mode_o(pmode));
    always #5 clk_sys_i = ~clk_sys_i; // 100 MHz
    // remembers any chip reset seen while a scenario runs
    always @(posedge clk_sys_i) if (crst === 1'b1) saw_rst = 1'b1;
    // ************************************************************
    // helpers
    // ************************************************************
    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
    endtask : cyc
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_sys_i);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk("apb timeout", 32'(a), 32'hFFFF_FFFF);
            close_out();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask : apb
    // waits for a chip reset pulse to rise and end, bounded
    task automatic wait_crst;
        int n;
        n = 0;
        while (crst !== 1'b1 && n < 50) begin cyc(1); n++; end
        while (crst !== 1'b0 && n < 100) begin cyc(1); n++; end
        if (n >= 50) begin
            chk("chip reset pulse", 32'(n), 32'h0);
            close_out();
        end
        cyc(6);
    endtask : wait_crst
    // slow low-speed oscillator periods, eight system cycles each
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge clk_sys_i);
            lso <= 1'b1;
            cyc(4);
            lso <= 1'b0;
            cyc(3);
        end
    endtask : tick
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        cyc(10);
        rst_i <= 1'b0;
        wait_crst();
        chk("mode before supply good", 32'(pmode), 32'h01);
        pg <= 1'b1;
        cyc(6);
        chk("mode active", 32'(pmode), 32'h02);
        apb(1'b0, OFF_RST_CAUSE, '0); chk("cause pin", rd, 32'h1);
        chk("imo reset", 32'(internal_main_oscillator), 32'h18);
        chk("ws at 24", 32'(ws), 32'h1);
        apb(1'b1, OFF_RST_CAUSE, 32'hF); apb(1'b0, OFF_RST_CAUSE, '0); chk("cause clr", rd, '0);
        apb(1'b1, OFF_IMO_FREQ, 32'h30); cyc(2); chk("ws at 48", 32'(ws), 32'h2);
        apb(1'b1, OFF_IMO_FREQ, 32'h31); apb(1'b0, OFF_IMO_FREQ, '0); chk("imo max", rd, 32'h30);
        apb(1'b1, OFF_IMO_FREQ, 32'h03); cyc(2); chk("imo min", 32'(internal_main_oscillator), 32'h3);
        // every source in turn; gate must be shut early in each switch
        for (int s = 5; s >= 0; s--) begin
            apb(1'b1, OFF_ROOT_SEL, 32'(s)); cyc(2); chk("gate shut", 32'(gate), '0);
            cyc(10); chk("source", 32'(rsel), 32'(s));
            if (s == 3) chk("pll on", {pll_en, ws}, 32'h6);
        end
        apb(1'b0, 12'h030, '0); chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, OFF_DIV_BASE, 32'h2); apb(1'b1, OFF_DIV_BASE + 12'h034, 32'h3);
        cyc(8); np = 0; na = 0; nb = 0; ana_q = 1'b0;
        repeat (60) begin
            cyc(1); np += per[0]; na += ana; nb += plb[1];
            if (ana_q === 1'b1) chk("analog leads", 32'(per[0]), 32'h1);
            ana_q = ana;
        end
        chk("div0 pulses", np, 20); chk("analog pulses", na, 20);
        chk("div13 pulses", nb, 15);
        for (int i = 1; i <= 4; i++) begin
            apb(1'b1, OFF_PWR_REQ, 32'(i)); cyc(2); chk("low mode", 32'(pmode), 32'h2 << i);
            wake <= 1'b1; cyc(4); wake <= 1'b0; cyc(3); chk("woken", 32'(pmode), 32'h2);
        end
        low_voltage_detector <= 1'b1; saw_rst = 1'b0; cyc(5); chk("lv irq", {saw_rst, irq}, 32'h1);
        low_voltage_detector <= 1'b0;
        apb(1'b1, OFF_SW_RST, SW_RST_KEY); wait_crst();
        apb(1'b0, OFF_RST_CAUSE, '0); chk("cause sw", rd, 32'h2);
        apb(1'b1, OFF_RST_CAUSE, 32'hF);
        apb(1'b1, OFF_WDT_MATCH, 32'h2); apb(1'b1, OFF_WDT_CTRL, 32'h1);
        saw_rst = 1'b0; tick(2); apb(1'b1, OFF_WDT_SVC, WDT_SVC_KEY); tick(2);
        apb(1'b0, OFF_WDT_COUNT, '0); chk("wdt count", rd, 32'h2);
        chk("serviced", 32'(saw_rst), '0);
        apb(1'b1, OFF_PWR_REQ, 32'(PREQ_DEEP)); tick(1); wait_crst();
        apb(1'b0, OFF_RST_CAUSE, '0); chk("cause wdt", rd, 32'h4);
        apb(1'b1, OFF_RST_CAUSE, 32'hF);
        brownout_detector <= 1'b1; cyc(4); brownout_detector <= 1'b0; wait_crst();
        apb(1'b0, OFF_RST_CAUSE, '0); chk("cause bod", rd, 32'h8);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
